/* File: inc/fsr_pkg.sv */
// constants and register map of the fault status register bank
package fsr_pkg;

    // bus widths
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int REG_W  = 16;
    localparam int IDX_W  = 6;

    // register indices; byte address is four times the index
    localparam logic [IDX_W-1:0] IDX_FAULT_SUMMARY = 6'h00;
    localparam logic [IDX_W-1:0] IDX_FAULT_CLEAR   = 6'h10;
    localparam logic [IDX_W-1:0] IDX_IRQ_STATUS    = 6'h11;
    localparam logic [IDX_W-1:0] IDX_IRQ_MASK      = 6'h12;
    localparam logic [IDX_W-1:0] IDX_ONETIME_MEMORY_PROGRAM_COMMAND      = 6'h13;

    // reset values
    localparam logic [REG_W-1:0] FAULT_SUMMARY_RST = 16'h0000;
    localparam logic [REG_W-1:0] IRQ_MASK_RST      = 16'h0000;
    localparam logic [7:0]       USER_IDENTIFIER_FIELD_RST       = 8'h00;

    // fault summary field positions
    localparam int POS_SENSE_OC_LO   = 0;
    localparam int POS_SENSE_OC_HI   = 2;
    localparam int POS_CHARGE_PUMP   = 3;
    localparam int POS_LOGIC_OC      = 4;
    localparam int POS_LOGIC_UV      = 5;
    localparam int POS_LOGIC_OV      = 6;
    localparam int POS_BUCK_OC       = 7;
    localparam int POS_OT_SHUTDOWN   = 8;
    localparam int POS_OT_WARNING    = 9;
    localparam int POS_LOCKED_ROTOR  = 10;
    localparam int POS_WATCHDOG      = 11;
    localparam int POS_ONETIME_MEM   = 12;
    localparam int FAULT_BITS        = 13;

    // clear register and program register fields
    localparam int POS_CLEAR_ALL     = 0;
    localparam int POS_PROG_CMD      = 0;
    localparam int POS_USER_IDENTIFIER_FIELD_LO    = 8;
    localparam int POS_USER_IDENTIFIER_FIELD_HI    = 15;

    // bus response codes
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

/* File: rtl/fsr_fault_status.sv */
// fault summary register bank with AXI4-Lite slave and interrupt
//
// Functional notes
// - the fault summary sits at index zero and is all zeros after reset.
// - a fault or warning sets its summary bit to one, one meaning it happened.
// - bits 2..0 flag sense amplifier overcurrent for phases A, B and C.
// - bit 3 flags a fault of either the low-side or the high-side pump.
// - bits 4, 5, 6 flag logic supply overcurrent, undervoltage, overvoltage.
// - bit 7 flags a buck converter overcurrent trip.
// - bit 8 flags overtemperature shutdown and bit 9 overtemperature warning.
// - bit 10 flags a locked rotor found from the Hall inputs.
// - bit 11 flags a watchdog fault and bit 12 a one-time memory fault.
// - bits 15..13 of the fault summary always read as zero.
// - writes to read-only fields change nothing and have no side effect.
// - hardware-updated fields are only read by the host.
// - write-only fields accept writes and read back as zero.
// - read/write fields return the value last written.
// - a program command is taken only in standby; user_identifier_field is always writable.
`timescale 1ns/1ps
`default_nettype none

module fsr_fault_status
    import fsr_pkg::*;
(
    // clock and reset
    input  wire logic              clock_i,
    input  wire logic              reset_n_i,
    // write address channel
    input  wire logic              awvalid_i,
    output logic                   awready_o,
    input  wire logic [ADDR_W-1:0] awaddr_i,
    input  wire logic [2:0]        awprot_i,
    // write data channel
    input  wire logic              wvalid_i,
    output logic                   wready_o,
    input  wire logic [DATA_W-1:0] wdata_i,
    input  wire logic [3:0]        wstrb_i,
    // write response channel
    output logic                   bvalid_o,
    input  wire logic              bready_i,
    output logic [1:0]             bresp_o,
    // read address channel
    input  wire logic              arvalid_i,
    output logic                   arready_o,
    input  wire logic [ADDR_W-1:0] araddr_i,
    input  wire logic [2:0]        arprot_i,
    // read data channel
    output logic                   rvalid_o,
    input  wire logic              rready_i,
    output logic [DATA_W-1:0]      rdata_o,
    output logic [1:0]             rresp_o,
    // fault detectors
    input  wire logic [2:0]        sense_amp_overcurrent_flags_i,
    input  wire logic              charge_pump_lowside_fault_i,
    input  wire logic              charge_pump_highside_fault_i,
    input  wire logic              logic_supply_overcurrent_fault_i,
    input  wire logic              logic_supply_undervoltage_fault_i,
    input  wire logic              logic_supply_overvoltage_fault_i,
    input  wire logic              buck_overcurrent_fault_i,
    input  wire logic              overtemp_shutdown_fault_i,
    input  wire logic              overtemp_warning_flag_i,
    input  wire logic              locked_rotor_fault_i,
    input  wire logic              watchdog_fault_i,
    input  wire logic              onetime_memory_fault_i,
    // device mode and one-time memory
    input  wire logic              standby_i,
    output logic                   onetime_memory_program_command_o,
    output logic [7:0]             user_identifier_field_o,
    // interrupt
    output logic                   irq_o
);

    // register index hit for a byte address
    function automatic logic idx_hit(input logic [ADDR_W-1:0] addr,
                                     input logic [IDX_W-1:0]  idx);
        idx_hit = (addr[ADDR_W-1:2] == idx);
    endfunction

    // merge new data into a 16-bit register by byte lanes
    function automatic logic [REG_W-1:0] lane_merge(
        input logic [REG_W-1:0] old_v,
        input logic [REG_W-1:0] new_v,
        input logic [1:0]       strb);
        lane_merge = {strb[1] ? new_v[15:8] : old_v[15:8],
                      strb[0] ? new_v[7:0]  : old_v[7:0]};
    endfunction

    // state
    logic                   aw_held_r;
    logic [ADDR_W-1:0]      aw_addr_r;
    logic                   w_held_r;
    logic [DATA_W-1:0]      w_data_r;
    logic [3:0]             w_strb_r;
    logic                   bvalid_r;
    logic [1:0]             bresp_r;
    logic                   rvalid_r;
    logic [DATA_W-1:0]      rdata_r;
    logic [1:0]             rresp_r;
    logic [FAULT_BITS-1:0]  fault_summary_r;
    logic [FAULT_BITS-1:0]  fault_summary_nxt;
    logic [FAULT_BITS-1:0]  irq_status_r;
    logic [FAULT_BITS-1:0]  irq_status_nxt;
    logic [REG_W-1:0]       irq_mask_r;
    logic [7:0]             user_identifier_field_r;
    logic                   prog_pulse_r;

    // decode
    wire logic                  aw_take;
    wire logic                  w_take;
    wire logic                  do_write;
    wire logic                  ar_take;
    wire logic                  wr_summary;
    wire logic                  wr_clear;
    wire logic                  wr_irq_status;
    wire logic                  wr_mask;
    wire logic                  wr_prog;
    wire logic                  wr_mapped;
    wire logic                  rd_summary;
    wire logic                  rd_clear;
    wire logic                  rd_irq_status;
    wire logic                  rd_mask;
    wire logic                  rd_prog;
    wire logic                  rd_mapped;
    wire logic                  clear_faults;
    wire logic                  irq_read_clear;
    wire logic                  prog_request;
    wire logic [FAULT_BITS-1:0] fault_events;
    wire logic [REG_W-1:0]      summary_word;
    wire logic [REG_W-1:0]      irq_word;
    wire logic [REG_W-1:0]      prog_word;
    wire logic [REG_W-1:0]      read_word;

    // channel handshakes; one write and one read in flight
    assign awready_o = !aw_held_r && !bvalid_r;
    assign wready_o  = !w_held_r && !bvalid_r;
    assign arready_o = !rvalid_r;
    assign aw_take   = awvalid_i && awready_o;
    assign w_take    = wvalid_i && wready_o;
    assign ar_take   = arvalid_i && arready_o;
    assign do_write  = aw_held_r && w_held_r && !bvalid_r;

    // write decode
    assign wr_summary    = idx_hit(aw_addr_r, IDX_FAULT_SUMMARY);
    assign wr_clear      = idx_hit(aw_addr_r, IDX_FAULT_CLEAR);
    assign wr_irq_status = idx_hit(aw_addr_r, IDX_IRQ_STATUS);
    assign wr_mask       = idx_hit(aw_addr_r, IDX_IRQ_MASK);
    assign wr_prog       = idx_hit(aw_addr_r, IDX_ONETIME_MEMORY_PROGRAM_COMMAND);
    assign wr_mapped     = wr_summary || wr_clear || wr_irq_status
                           || wr_mask || wr_prog;

    // read decode
    assign rd_summary    = idx_hit(araddr_i, IDX_FAULT_SUMMARY);
    assign rd_clear      = idx_hit(araddr_i, IDX_FAULT_CLEAR);
    assign rd_irq_status = idx_hit(araddr_i, IDX_IRQ_STATUS);
    assign rd_mask       = idx_hit(araddr_i, IDX_IRQ_MASK);
    assign rd_prog       = idx_hit(araddr_i, IDX_ONETIME_MEMORY_PROGRAM_COMMAND);
    assign rd_mapped     = rd_summary || rd_clear || rd_irq_status
                           || rd_mask || rd_prog;

    // clear command is a write-only strobe in lane zero
    assign clear_faults = do_write && wr_clear && w_strb_r[0]
                          && w_data_r[POS_CLEAR_ALL];
    assign irq_read_clear = ar_take && rd_irq_status;

    // program command only honoured in standby
    assign prog_request = do_write && wr_prog && w_strb_r[0]
                          && w_data_r[POS_PROG_CMD] && standby_i;

    // fault sources mapped onto summary bit positions
    assign fault_events[POS_SENSE_OC_HI:POS_SENSE_OC_LO] =
        sense_amp_overcurrent_flags_i;
    assign fault_events[POS_CHARGE_PUMP] = charge_pump_lowside_fault_i
        || charge_pump_highside_fault_i;
    assign fault_events[POS_LOGIC_OC] =
        logic_supply_overcurrent_fault_i;
    assign fault_events[POS_LOGIC_UV] = logic_supply_undervoltage_fault_i;
    assign fault_events[POS_LOGIC_OV] = logic_supply_overvoltage_fault_i;
    assign fault_events[POS_BUCK_OC] = buck_overcurrent_fault_i;
    assign fault_events[POS_OT_SHUTDOWN] = overtemp_shutdown_fault_i;
    assign fault_events[POS_OT_WARNING] = overtemp_warning_flag_i;
    assign fault_events[POS_LOCKED_ROTOR] = locked_rotor_fault_i;
    assign fault_events[POS_WATCHDOG] = watchdog_fault_i;
    assign fault_events[POS_ONETIME_MEM] = onetime_memory_fault_i;

    // sticky flags: a new event wins over a clear in the same cycle
    assign fault_summary_nxt = (clear_faults ? '0 : fault_summary_r)
                               | fault_events;
    assign irq_status_nxt = (irq_read_clear ? '0 : irq_status_r)
                            | fault_events;

    // read words; reserved and write-only bits read zero
    assign summary_word = {{(REG_W-FAULT_BITS){1'b0}},
                           fault_summary_r};
    assign irq_word  = {{(REG_W-FAULT_BITS){1'b0}}, irq_status_r};
    assign prog_word = {user_identifier_field_r, 8'h00};
    assign read_word = rd_summary    ? summary_word :
                       rd_irq_status ? irq_word :
                       rd_mask       ? irq_mask_r :
                       rd_prog       ? prog_word :
                       16'h0000;

    // outputs
    assign bvalid_o = bvalid_r;
    assign bresp_o  = bresp_r;
    assign rvalid_o = rvalid_r;
    assign rdata_o  = rdata_r;
    assign rresp_o  = rresp_r;
    assign onetime_memory_program_command_o = prog_pulse_r;
    assign user_identifier_field_o = user_identifier_field_r;
    assign irq_o = |({{(REG_W-FAULT_BITS){1'b0}}, irq_status_r}
                     & irq_mask_r);

    // write address and data capture
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            aw_held_r <= 1'b0;
            aw_addr_r <= '0;
            w_held_r  <= 1'b0;
            w_data_r  <= '0;
            w_strb_r  <= '0;
        end else begin
            if (aw_take) begin
                aw_held_r <= 1'b1;
                aw_addr_r <= awaddr_i;
            end else if (do_write) begin
                aw_held_r <= 1'b0;
            end
            if (w_take) begin
                w_held_r <= 1'b1;
                w_data_r <= wdata_i;
                w_strb_r <= wstrb_i;
            end else if (do_write) begin
                w_held_r <= 1'b0;
            end
        end
    end

    // write response; unmapped addresses answer with an error
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            bvalid_r <= 1'b0;
            bresp_r  <= RESP_OKAY;
        end else if (do_write) begin
            bvalid_r <= 1'b1;
            bresp_r  <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
        end else if (bready_i) begin
            bvalid_r <= 1'b0;
        end
    end

    // read response
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rvalid_r <= 1'b0;
            rdata_r  <= '0;
            rresp_r  <= RESP_OKAY;
        end else if (ar_take) begin
            rvalid_r <= 1'b1;
            rdata_r  <= {{(DATA_W-REG_W){1'b0}}, read_word};
            rresp_r  <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
        end else if (rready_i) begin
            rvalid_r <= 1'b0;
        end
    end

    // hardware-owned flags; bus writes reach only the fault summary, through the clear command; a read clears the irq status
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            fault_summary_r <= FAULT_SUMMARY_RST[FAULT_BITS-1:0];
            irq_status_r    <= '0;
        end else begin
            fault_summary_r <= fault_summary_nxt;
            irq_status_r    <= irq_status_nxt;
        end
    end

    // software-owned fields and the program strobe
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            irq_mask_r   <= IRQ_MASK_RST;
            user_identifier_field_r    <= USER_IDENTIFIER_FIELD_RST;
            prog_pulse_r <= 1'b0;
        end else begin
            if (do_write && wr_mask) begin
                irq_mask_r <= lane_merge(irq_mask_r, w_data_r[REG_W-1:0],
                                         w_strb_r[1:0]);
            end
            if (do_write && wr_prog && w_strb_r[1]) begin
                user_identifier_field_r <= w_data_r[POS_USER_IDENTIFIER_FIELD_HI:POS_USER_IDENTIFIER_FIELD_LO];
            end
            prog_pulse_r <= prog_request;
        end
    end

    // checks
    a_reserved_zero: assert property (@(posedge clock_i)
        disable iff (!reset_n_i)
        (ar_take && rd_summary) |=> (rdata_r[REG_W-1:FAULT_BITS] == '0))
        else $error("reserved summary bits not zero");

    a_fault_sets: assert property (@(posedge clock_i)
        disable iff (!reset_n_i)
        (fault_events != '0) |=>
            ((fault_summary_r & $past(fault_events)) == $past(fault_events)))
        else $error("fault event did not set its bit");

    a_fault_sticky: assert property (@(posedge clock_i)
        disable iff (!reset_n_i)
        !clear_faults |=> ((fault_summary_r & $past(fault_summary_r))
                           == $past(fault_summary_r)))
        else $error("fault bit dropped without clear");

    a_pump_combined: assert property (@(posedge clock_i)
        disable iff (!reset_n_i)
        (charge_pump_highside_fault_i || charge_pump_lowside_fault_i)
            |=> fault_summary_r[POS_CHARGE_PUMP])
        else $error("pump fault not flagged");

    a_phase_c_bit: assert property (@(posedge clock_i)
        disable iff (!reset_n_i)
        sense_amp_overcurrent_flags_i[2] |=> summary_word[POS_SENSE_OC_HI])
        else $error("phase C overcurrent not in bit 2");

    a_clear_works: assert property (@(posedge clock_i)
        disable iff (!reset_n_i)
        (clear_faults && fault_events == '0) |=> (fault_summary_r == '0))
        else $error("clear command left faults set");

    a_ro_write_ignored: assert property (@(posedge clock_i)
        disable iff (!reset_n_i)
        (do_write && wr_summary && fault_events == '0)
            |=> $stable(fault_summary_r) && $stable(irq_mask_r))
        else $error("write to read-only register had effect");

    a_wo_reads_zero: assert property (@(posedge clock_i)
        disable iff (!reset_n_i)
        (ar_take && (rd_clear || rd_prog)) |=> (rdata_r[7:0] == 8'h00))
        else $error("write-only field read non-zero");

    // a full-lane mask write is stored as written
    a_mask_readback: assert property (@(posedge clock_i)
        disable iff (!reset_n_i)
        (do_write && wr_mask && w_strb_r[1:0] == 2'h3)
            |=> (irq_mask_r == $past(w_data_r[REG_W-1:0])))
        else $error("mask write not stored");

    a_prog_standby: assert property (@(posedge clock_i)
        disable iff (!reset_n_i)
        onetime_memory_program_command_o |->
            $past(standby_i) && $past(do_write && wr_prog))
        else $error("program command outside standby");

    // every write answered next cycle, unmapped ones with an error
    a_write_answer: assert property (@(posedge clock_i)
        disable iff (!reset_n_i)
        do_write |=> bvalid_o
            && (bresp_o == ($past(wr_mapped) ? RESP_OKAY : RESP_SLVERR)))
        else $error("write not answered in one cycle");

    a_irq_level: assert property (@(posedge clock_i)
        disable iff (!reset_n_i)
        irq_o == ((irq_status_r & irq_mask_r[FAULT_BITS-1:0]) != '0))
        else $error("interrupt level wrong");

    // main scenarios
    c_fault_then_clear: cover property (@(posedge clock_i)
        disable iff (!reset_n_i)
        (fault_summary_r != '0) ##[1:20] clear_faults);
    c_clear_collides: cover property (@(posedge clock_i)
        disable iff (!reset_n_i)
        clear_faults && (fault_events != '0));
    c_prog_refused: cover property (@(posedge clock_i)
        disable iff (!reset_n_i)
        do_write && wr_prog && w_data_r[POS_PROG_CMD] && !standby_i);
    c_irq_raised: cover property (@(posedge clock_i)
        disable iff (!reset_n_i)
        $rose(irq_o));

endmodule

`default_nettype wire

/* File: verification/fsr_host_model.sv */
// host microcontroller model: register bus master with write and read tasks
`timescale 1ns/1ps
`default_nettype none

module fsr_host_model
    import fsr_pkg::*;
(
    // clock
    input  wire logic              clock_i,
    // write channels
    output logic                   awvalid_o,
    input  wire logic              awready_i,
    output logic [ADDR_W-1:0]      awaddr_o,
    output logic                   wvalid_o,
    input  wire logic              wready_i,
    output logic [DATA_W-1:0]      wdata_o,
    output logic [3:0]             wstrb_o,
    input  wire logic              bvalid_i,
    output logic                   bready_o,
    input  wire logic [1:0]        bresp_i,
    // read channels
    output logic                   arvalid_o,
    input  wire logic              arready_i,
    output logic [ADDR_W-1:0]      araddr_o,
    input  wire logic              rvalid_i,
    output logic                   rready_o,
    input  wire logic [DATA_W-1:0] rdata_i,
    input  wire logic [1:0]        rresp_i
);

    // idle bus at time zero
    initial begin
        {awvalid_o, wvalid_o, bready_o, arvalid_o, rready_o} = 5'h00;
        awaddr_o = 8'h00;
        araddr_o = 8'h00;
        wdata_o  = 32'h0000_0000;
        wstrb_o  = 4'h0;
    end

    // one write; clearing faults goes through this to the clear register
    task automatic write(input logic [ADDR_W-1:0] a,
                         input logic [DATA_W-1:0] d,
                         input logic [3:0]        s,
                         output logic [1:0]       resp);
        @(posedge clock_i);
        awvalid_o <= 1'b1;
        awaddr_o  <= a;
        wvalid_o  <= 1'b1;
        wdata_o   <= d;
        wstrb_o   <= s;
        bready_o  <= 1'b1;
        forever begin
            @(posedge clock_i);
            // released address and data lines show inverted garbage, not the last value
            if (awvalid_o && awready_i) begin
                awvalid_o <= 1'b0;
                awaddr_o  <= ~a;
            end
            if (wvalid_o && wready_i) begin
                wvalid_o <= 1'b0;
                wdata_o  <= ~d;
            end
            if (bvalid_i) begin
                resp = bresp_i;
                bready_o <= 1'b0;
                break;
            end
        end
    endtask

    // one read; returns data and response at the handshake edge
    task automatic read(input logic [ADDR_W-1:0] a,
                        output logic [DATA_W-1:0] d,
                        output logic [1:0]        resp);
        @(posedge clock_i);
        arvalid_o <= 1'b1;
        araddr_o  <= a;
        rready_o  <= 1'b1;
        forever begin
            @(posedge clock_i);
            if (arvalid_o && arready_i) begin
                arvalid_o <= 1'b0;
                araddr_o  <= ~a;
            end
            if (rvalid_i) begin
                d    = rdata_i;
                resp = rresp_i;
                rready_o <= 1'b0;
                break;
            end
        end
    endtask

endmodule

`default_nettype wire

/* File: verification/fault_status_register_bank_test.sv */
// self-checking testbench of the fault status register bank
`timescale 1ns/1ps
`default_nettype none

module fault_status_register_bank_test
    import fsr_pkg::*;
;
    logic              clock_i = 1'b0;
    logic              reset_n_i = 1'b0;
    logic              standby = 1'b0;
    logic [13:0]       ev = 14'h0000;
    logic              awvalid, awready, wvalid, wready, bvalid, bready;
    logic              arvalid, arready, rvalid, rready, prog, irq;
    logic [ADDR_W-1:0] awaddr, araddr;
    logic [DATA_W-1:0] wdata, rdata;
    logic [3:0]        wstrb;
    logic [1:0]        bresp, rresp;
    logic [7:0]        uid;
    int                num_errors = 0;
    int                compares = 0;
    int                cycles = 0;
    int                pulses = 0;

    // 20 MHz clock
    always #25 clock_i = ~clock_i;

    fsr_host_model host (.clock_i(clock_i), .awvalid_o(awvalid),
        .awready_i(awready), .awaddr_o(awaddr), .wvalid_o(wvalid),
        .wready_i(wready), .wdata_o(wdata), .wstrb_o(wstrb),
        .bvalid_i(bvalid), .bready_o(bready), .bresp_i(bresp),
        .arvalid_o(arvalid), .arready_i(arready), .araddr_o(araddr),
        .rvalid_i(rvalid), .rready_o(rready), .rdata_i(rdata),
        .rresp_i(rresp));

    fsr_fault_status uut (.clock_i(clock_i), .reset_n_i(reset_n_i),
        .awvalid_i(awvalid), .awready_o(awready), .awaddr_i(awaddr),
        .awprot_i(3'h0), .wvalid_i(wvalid), .wready_o(wready),
        .wdata_i(wdata), .wstrb_i(wstrb), .bvalid_o(bvalid),
        .bready_i(bready), .bresp_o(bresp), .arvalid_i(arvalid),
        .arready_o(arready), .araddr_i(araddr), .arprot_i(3'h0),
        .rvalid_o(rvalid), .rready_i(rready), .rdata_o(rdata),
        .rresp_o(rresp), .sense_amp_overcurrent_flags_i(ev[2:0]),
        .charge_pump_lowside_fault_i(ev[3]),
        .charge_pump_highside_fault_i(ev[13]),
        .logic_supply_overcurrent_fault_i(ev[4]),
        .logic_supply_undervoltage_fault_i(ev[5]),
        .logic_supply_overvoltage_fault_i(ev[6]),
        .buck_overcurrent_fault_i(ev[7]),
        .overtemp_shutdown_fault_i(ev[8]),
        .overtemp_warning_flag_i(ev[9]), .locked_rotor_fault_i(ev[10]),
        .watchdog_fault_i(ev[11]), .onetime_memory_fault_i(ev[12]),
        .standby_i(standby), .onetime_memory_program_command_o(prog),
        .user_identifier_field_o(uid), .irq_o(irq));

    // program pulse counter and hang guard
    always @(posedge clock_i) begin
        cycles <= cycles + 1;
        if (prog === 1'b1)
            pulses <= pulses + 1;
        if (cycles == 6000) begin
            num_errors++;
            conclude();
        end
    end

    task automatic check(input string n, input logic [31:0] seen, exp);
        compares++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", n, exp, seen);
        end
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e,
                      input logic [1:0] er = RESP_OKAY);
        logic [31:0] d;
        logic [1:0]  r;
        host.read(a, d, r);
        check("rdata", d, e);
        check("rresp", {30'h0, r}, {30'h0, er});
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] s, input logic [1:0] er = RESP_OKAY);
        logic [1:0] r;
        host.write(a, d, s, r);
        check("bresp", {30'h0, r}, {30'h0, er});
    endtask

    // one-cycle detector event on input line i
    task automatic pulse(input int i);
        @(posedge clock_i);
        ev <= 14'h0001 << i;
        @(posedge clock_i);
        ev <= 14'h0000;
    endtask

    task automatic conclude();
        $display("checks %0d errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    initial begin
        repeat (3) @(posedge clock_i);
        reset_n_i <= 1'b1;
        rd(8'h00, 32'h0000_0000);
        rd(8'h48, 32'h0000_0000);
        rd(8'h44, 32'h0000_0000);
        // every event source lands on its bit, both pump inputs on bit 3, and sticks until cleared
        for (int i = 0; i < 14; i++) begin
            logic [31:0] bit_exp;
            bit_exp = 32'h1 << ((i == 13) ? 3 : i);
            pulse(i);
            repeat (2) @(posedge clock_i);
            rd(8'h00, bit_exp);
            rd(8'h00, bit_exp);
            wr(8'h40, 32'h0000_0001, 4'h1);
            rd(8'h00, 32'h0000_0000);
        end
        rd(8'h44, 32'h0000_1FFF);
        rd(8'h44, 32'h0000_0000);
        // read-only places ignore writes
        pulse(8);
        wr(8'h00, 32'h0000_FFFF, 4'hF);
        wr(8'h44, 32'h0000_FFFF, 4'hF);
        rd(8'h00, 32'h0000_0100);
        rd(8'h44, 32'h0000_0100);
        // write-only and read/write fields
        rd(8'h40, 32'h0000_0000);
        wr(8'h4C, 32'h0000_A500, 4'h2);
        rd(8'h4C, 32'h0000_A500);
        check("user_identifier_field", {24'h0, uid}, 32'h0000_00A5);
        wr(8'h48, 32'h0000_FFFF, 4'hF);
        wr(8'h48, 32'h0000_0000, 4'h1);
        rd(8'h48, 32'h0000_FF00);
        // masked event stays quiet, unmasked event raises the interrupt
        wr(8'h48, 32'h0000_0010, 4'hF);
        pulse(5);
        repeat (2) @(posedge clock_i);
        check("irq", {31'h0, irq}, 32'h0);
        rd(8'h44, 32'h0000_0020);
        pulse(4);
        repeat (2) @(posedge clock_i);
        check("irq", {31'h0, irq}, 32'h1);
        rd(8'h44, 32'h0000_0010);
        @(posedge clock_i);
        check("irq", {31'h0, irq}, 32'h0);
        // program command taken in standby only, user_identifier_field always
        wr(8'h4C, 32'h0000_3C01, 4'h3);
        check("prog_idle", pulses, 0);
        check("user_identifier_field", {24'h0, uid}, 32'h0000_003C);
        standby <= 1'b1;
        wr(8'h4C, 32'h0000_3C01, 4'h3);
        repeat (2) @(posedge clock_i);
        check("prog_standby", pulses, 1);
        // unmapped address
        wr(8'h20, 32'h0000_FFFF, 4'hF, RESP_SLVERR);
        rd(8'h20, 32'h0000_0000, RESP_SLVERR);
        rd(8'h00, 32'h0000_0130);
        conclude();
    end

endmodule

`default_nettype wire
